//--- hdl/abs_datapath.v
// Execution datapath for add, AND, bit modify and bit-test-skip instructions
`timescale 1ns/10ps
`include "abs_map.vh"

module abs_datapath #(
    parameter DATA_W = `ABS_DATA_W,
    parameter ADDR_W = `ABS_ADDR_W,
    parameter WORD_W = `ABS_WORD_W
) (
    input  wire              clk,
    input  wire              rst_b,
    input  wire              instr_valid,
    input  wire [WORD_W-1:0] instr_word,
    input  wire [DATA_W-1:0] file_rd_data,
    output reg  [ADDR_W-1:0] file_rd_addr_r,
    output reg               file_wr_en_r,
    output reg  [ADDR_W-1:0] file_wr_addr_r,
    output reg  [DATA_W-1:0] file_wr_data_r,
    output reg  [DATA_W-1:0] accumulator_reg_r,
    output reg               byte_overflow_flag_r,
    output reg               nibble_carry_flag_r,
    output reg               result_nil_flag_r,
    output reg               op_done_r,
    output reg               nop_cycle_r,
    output reg               instr_discard_r,
    output reg               unsupported_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Field decode
    wire [1:0]        f_class;
    wire [1:0]        f_bop;
    wire [2:0]        f_pos;
    wire [ADDR_W-1:0] f_reg;
    wire              f_dest;
    wire [3:0]        f_byte_op;
    wire [3:0]        f_lit_op;
    wire [2:0]        f_lit_add;
    wire [DATA_W-1:0] f_imm;

    assign f_class   = instr_word[`ABS_CLASS_HI:`ABS_CLASS_LO];
    assign f_bop     = instr_word[`ABS_BOP_HI:`ABS_BOP_LO];
    assign f_pos     = instr_word[`ABS_POS_HI:`ABS_POS_LO];
    assign f_reg     = instr_word[`ABS_REG_HI:`ABS_REG_LO];
    assign f_dest    = instr_word[`ABS_DEST_BIT];
    assign f_byte_op = instr_word[`ABS_BYTE_OP_HI:`ABS_BYTE_OP_LO];
    assign f_lit_op  = instr_word[`ABS_LIT_OP_HI:`ABS_LIT_OP_LO];
    assign f_lit_add = instr_word[`ABS_LIT_ADD_HI:`ABS_LIT_ADD_LO];
    assign f_imm     = instr_word[`ABS_IMM_HI:`ABS_IMM_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Instruction kinds
    localparam [3:0] K_NONE     = 4'h0;
    localparam [3:0] K_ADD_IMM  = 4'h1;
    localparam [3:0] K_ADD_REG  = 4'h2;
    localparam [3:0] K_AND_IMM  = 4'h3;
    localparam [3:0] K_AND_REG  = 4'h4;
    localparam [3:0] K_CLR_BIT  = 4'h5;
    localparam [3:0] K_SET_BIT  = 4'h6;
    localparam [3:0] K_SKIP_ONE = 4'h7;
    localparam [3:0] K_SKIP_ZER = 4'h8;

    reg [3:0] kind;

    always @* begin
        kind = K_NONE;
        case (f_class)
            `ABS_CLASS_BIT: begin
                case (f_bop)
                    `ABS_BOP_CLEAR:     kind = K_CLR_BIT;
                    `ABS_BOP_SET:       kind = K_SET_BIT;
                    `ABS_BOP_SKIP_ZERO: kind = K_SKIP_ZER;
                    `ABS_BOP_SKIP_ONE:  kind = K_SKIP_ONE;
                    default:            kind = K_NONE;
                endcase
            end
            `ABS_CLASS_BYTE: begin
                if (f_byte_op == `ABS_OP_ADD_REG) begin
                    kind = K_ADD_REG;
                end else if (f_byte_op == `ABS_OP_AND_REG) begin
                    kind = K_AND_REG;
                end
            end
            `ABS_CLASS_LIT: begin
                if (f_lit_add == `ABS_OP_ADD_IMM) begin
                    kind = K_ADD_IMM;
                end else if (f_lit_op == `ABS_OP_AND_IMM) begin
                    kind = K_AND_IMM;
                end
            end
            default: kind = K_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operand select with forwarding of the pending file write
    wire              fwd_hit;
    wire [DATA_W-1:0] file_opnd;
    wire              is_lit;
    wire [DATA_W-1:0] opnd;

    assign fwd_hit   = file_wr_en_r && (file_wr_addr_r == f_reg);
    assign file_opnd = fwd_hit ? file_wr_data_r : file_rd_data;
    assign is_lit    = (kind == K_ADD_IMM) || (kind == K_AND_IMM);
    assign opnd      = is_lit ? f_imm : file_opnd;

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic unit
    wire [DATA_W-1:0] sum_val;
    wire              sum_carry;
    wire              sum_nib_carry;
    wire              sum_zero;
    wire [DATA_W-1:0] and_val;
    wire              and_zero;
    wire [DATA_W-1:0] clr_val;
    wire [DATA_W-1:0] set_val;
    wire              bit_val;

    abs_alu #(
        .DATA_W (DATA_W),
        .BIT_W  (`ABS_BIT_W)
    ) u_alu (
        .acc_val       (accumulator_reg_r),
        .opnd_val      (opnd),
        .bit_pos       (f_pos),
        .sum_val       (sum_val),
        .sum_carry     (sum_carry),
        .sum_nib_carry (sum_nib_carry),
        .sum_zero      (sum_zero),
        .and_val       (and_val),
        .and_zero      (and_zero),
        .clr_val       (clr_val),
        .set_val       (set_val),
        .bit_val       (bit_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    wire              exec;
    reg  [DATA_W-1:0] acc_nxt;
    reg               cy_nxt;
    reg               nib_nxt;
    reg               z_nxt;
    reg               wr_en_nxt;
    reg  [DATA_W-1:0] wr_data_nxt;
    reg               skip_nxt;

    // Instruction in the NOP cycle is thrown away
    assign exec = instr_valid && !nop_cycle_r;

    always @* begin
        acc_nxt     = accumulator_reg_r;
        cy_nxt      = byte_overflow_flag_r;
        nib_nxt     = nibble_carry_flag_r;
        z_nxt       = result_nil_flag_r;
        wr_en_nxt   = 1'b0;
        wr_data_nxt = file_wr_data_r;
        skip_nxt    = 1'b0;
        if (exec) begin
            case (kind)
                K_ADD_IMM: begin
                    acc_nxt = sum_val;
                    cy_nxt  = sum_carry;
                    nib_nxt = sum_nib_carry;
                    z_nxt   = sum_zero;
                end
                K_ADD_REG: begin
                    cy_nxt = sum_carry;
                    nib_nxt = sum_nib_carry;
                    z_nxt  = sum_zero;
                    if (f_dest == `ABS_DEST_FILE) begin
                        wr_en_nxt   = 1'b1;
                        wr_data_nxt = sum_val;
                    end else begin
                        acc_nxt = sum_val;
                    end
                end
                K_AND_IMM: begin
                    acc_nxt = and_val;
                    z_nxt   = and_zero;
                end
                K_AND_REG: begin
                    z_nxt = and_zero;
                    if (f_dest == `ABS_DEST_FILE) begin
                        wr_en_nxt   = 1'b1;
                        wr_data_nxt = and_val;
                    end else begin
                        acc_nxt = and_val;
                    end
                end
                K_CLR_BIT: begin
                    wr_en_nxt   = 1'b1;
                    wr_data_nxt = clr_val;
                end
                K_SET_BIT: begin
                    wr_en_nxt   = 1'b1;
                    wr_data_nxt = set_val;
                end
                K_SKIP_ONE: skip_nxt = bit_val;
                K_SKIP_ZER: skip_nxt = !bit_val;
                default: skip_nxt = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State and output registers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            accumulator_reg_r    <= `ABS_ACC_RST;
            byte_overflow_flag_r <= `ABS_FLAG_RST;
            nibble_carry_flag_r  <= `ABS_FLAG_RST;
            result_nil_flag_r    <= `ABS_FLAG_RST;
            file_wr_en_r         <= 1'b0;
            file_wr_addr_r       <= {ADDR_W{1'b0}};
            file_wr_data_r       <= {DATA_W{1'b0}};
            file_rd_addr_r       <= {ADDR_W{1'b0}};
            op_done_r            <= 1'b0;
            nop_cycle_r          <= 1'b0;
            instr_discard_r      <= 1'b0;
            unsupported_r        <= 1'b0;
        end else begin
            accumulator_reg_r    <= acc_nxt;
            byte_overflow_flag_r <= cy_nxt;
            nibble_carry_flag_r  <= nib_nxt;
            result_nil_flag_r    <= z_nxt;
            file_wr_en_r         <= wr_en_nxt;
            if (exec) begin
                file_wr_addr_r <= f_reg;
                file_rd_addr_r <= f_reg;
            end
            file_wr_data_r       <= wr_data_nxt;
            op_done_r            <= exec && (kind != K_NONE);
            nop_cycle_r          <= skip_nxt;
            instr_discard_r      <= instr_valid && nop_cycle_r;
            unsupported_r        <= exec && (kind == K_NONE);
        end
    end

endmodule

//--- hdl/abs_map.vh
// Opcode fields, opcode codes, reset values and cycle counts of the datapath
`ifndef ABS_MAP_VH
`define ABS_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Word and field widths
`define ABS_WORD_W        14
`define ABS_DATA_W        8
`define ABS_ADDR_W        7
`define ABS_BIT_W         3

////////////////////////////////////////////////////////////////////////////////
// Field positions in the 14-bit instruction word
`define ABS_CLASS_HI      13
`define ABS_CLASS_LO      12
`define ABS_BOP_HI        11
`define ABS_BOP_LO        10
`define ABS_POS_HI        9
`define ABS_POS_LO        7
`define ABS_REG_HI        6
`define ABS_REG_LO        0
`define ABS_DEST_BIT      7
`define ABS_BYTE_OP_HI    11
`define ABS_BYTE_OP_LO    8
`define ABS_IMM_HI        7
`define ABS_IMM_LO        0
`define ABS_LIT_OP_HI     11
`define ABS_LIT_OP_LO     8
`define ABS_LIT_ADD_HI    11
`define ABS_LIT_ADD_LO    9

////////////////////////////////////////////////////////////////////////////////
// Class codes in the two top bits
`define ABS_CLASS_BYTE    2'h0
`define ABS_CLASS_BIT     2'h1
`define ABS_CLASS_LIT     2'h3

////////////////////////////////////////////////////////////////////////////////
// Byte-oriented operations
`define ABS_OP_ADD_REG    4'h7
`define ABS_OP_AND_REG    4'h5

////////////////////////////////////////////////////////////////////////////////
// Literal operations
`define ABS_OP_AND_IMM    4'h9
`define ABS_OP_ADD_IMM    3'h7

////////////////////////////////////////////////////////////////////////////////
// Bit-oriented operations
`define ABS_BOP_CLEAR     2'h0
`define ABS_BOP_SET       2'h1
`define ABS_BOP_SKIP_ZERO 2'h2
`define ABS_BOP_SKIP_ONE  2'h3

////////////////////////////////////////////////////////////////////////////////
// Destination select
`define ABS_DEST_ACC      1'b0
`define ABS_DEST_FILE     1'b1

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define ABS_ACC_RST       8'h00
`define ABS_FLAG_RST      1'b0

////////////////////////////////////////////////////////////////////////////////
// Cycle counts
`define ABS_CYC_PLAIN     1
`define ABS_CYC_SKIP      2

`endif

//--- hdl/abs_alu.v
// Combinational arithmetic, logic and bit-modify unit of the datapath
`timescale 1ns/10ps

module abs_alu #(
    parameter DATA_W = 8,
    parameter BIT_W  = 3
) (
    input  wire [DATA_W-1:0] acc_val,
    input  wire [DATA_W-1:0] opnd_val,
    input  wire [BIT_W-1:0]  bit_pos,
    output wire [DATA_W-1:0] sum_val,
    output wire              sum_carry,
    output wire              sum_nib_carry,
    output wire              sum_zero,
    output wire [DATA_W-1:0] and_val,
    output wire              and_zero,
    output wire [DATA_W-1:0] clr_val,
    output wire [DATA_W-1:0] set_val,
    output wire              bit_val
);

    wire [DATA_W:0]   sum_full;
    wire [4:0]        nib_sum;
    wire [DATA_W-1:0] bit_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Add with carry out of bit 7 and bit 3
    assign sum_full      = {1'b0, acc_val} + {1'b0, opnd_val};
    assign sum_val       = sum_full[DATA_W-1:0];
    assign sum_carry     = sum_full[DATA_W];
    assign nib_sum       = {1'b0, acc_val[3:0]} + {1'b0, opnd_val[3:0]};
    assign sum_nib_carry = nib_sum[4];
    assign sum_zero      = (sum_val == {DATA_W{1'b0}});

    ////////////////////////////////////////////////////////////////////////////
    // Bitwise AND
    assign and_val  = acc_val & opnd_val;
    assign and_zero = (and_val == {DATA_W{1'b0}});

    ////////////////////////////////////////////////////////////////////////////
    // Bit modify of the one bit at bit_pos, others kept
    assign bit_mask = {{(DATA_W-1){1'b0}}, 1'b1} << bit_pos;
    assign clr_val  = opnd_val & ~bit_mask;
    assign set_val  = opnd_val | bit_mask;
    assign bit_val  = opnd_val[bit_pos];

endmodule

//--- tb/abs_datapath_props.sv
// Checker of the datapath instruction behaviour
`timescale 1ns/10ps
module abs_datapath_props (
    input logic        clk,
    input logic        rst_b,
    input logic        instr_valid,
    input logic [13:0] instr_word,
    input logic [7:0]  file_rd_data,
    input logic [6:0]  file_rd_addr_r,
    input logic        file_wr_en_r,
    input logic [6:0]  file_wr_addr_r,
    input logic [7:0]  file_wr_data_r,
    input logic [7:0]  accumulator_reg_r,
    input logic        byte_overflow_flag_r,
    input logic        nibble_carry_flag_r,
    input logic        result_nil_flag_r,
    input logic        op_done_r,
    input logic        nop_cycle_r,
    input logic        instr_discard_r,
    input logic        unsupported_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////
    // Decode and operand with pending write
    wire       tk  = instr_valid && !nop_cycle_r;
    wire       fwd = file_wr_en_r && file_wr_addr_r == instr_word[6:0];
    wire [7:0] opd = fwd ? file_wr_data_r : file_rd_data;
    wire       bop = tk && instr_word[13:12] == 2'h1;
    wire       aim = tk && instr_word[13:9] == 5'h1f;
    wire       arg = tk && instr_word[13:8] == 6'h07;
    wire       ani = tk && instr_word[13:8] == 6'h39;
    ////////////////////////////////////////////////////////////////////////////
    // Properties
    sequence s_test;
        bop && instr_word[11];
    endsequence
    sequence s_hit;
        s_test ##0 opd[instr_word[9:7]] == instr_word[10];
    endsequence
    sequence s_miss;
        s_test ##0 opd[instr_word[9:7]] != instr_word[10];
    endsequence
    property p_skip;
        s_hit |=> nop_cycle_r && op_done_r ##1 !nop_cycle_r;
    endproperty
    property p_noskip;
        s_miss |=> !nop_cycle_r && op_done_r;
    endproperty
    property p_disc;
        instr_valid && nop_cycle_r |=> instr_discard_r && !op_done_r && !file_wr_en_r;
    endproperty
    property p_aim;
        logic [8:0] v;
        (aim, v = {1'b0, accumulator_reg_r} + instr_word[7:0]) |=>
            {byte_overflow_flag_r, accumulator_reg_r} == v && result_nil_flag_r == (v[7:0] == 0);
    endproperty
    property p_nib;
        logic [4:0] n;
        (arg, n = {1'b0, accumulator_reg_r[3:0]} + opd[3:0]) |=> nibble_carry_flag_r == n[4];
    endproperty
    property p_argd;
        logic [7:0] v;
        (arg && instr_word[7], v = accumulator_reg_r + opd) |=>
            file_wr_en_r && file_wr_data_r == v && $stable(accumulator_reg_r);
    endproperty
    property p_bset;
        logic [7:0] v;
        (bop && instr_word[11:10] == 2'h1, v = opd | (8'h1 << instr_word[9:7])) |=>
            file_wr_en_r && file_wr_data_r == v;
    endproperty
    property p_bflag;
        bop |=> $stable({byte_overflow_flag_r, nibble_carry_flag_r, result_nil_flag_r});
    endproperty
    property p_andi;
        logic [7:0] v;
        (ani, v = accumulator_reg_r & instr_word[7:0]) |=> accumulator_reg_r == v &&
            result_nil_flag_r == (v == 0) && $stable({byte_overflow_flag_r, nibble_carry_flag_r});
    endproperty
    property p_andr;
        logic [8:0] v;
        (tk && instr_word[13:8] == 6'h05, v = {instr_word[7], accumulator_reg_r & opd}) |=>
            (v[8] ? file_wr_en_r && file_wr_data_r == v[7:0]
                  : !file_wr_en_r && accumulator_reg_r == v[7:0]) &&
            result_nil_flag_r == (v[7:0] == 0) &&
            $stable({byte_overflow_flag_r, nibble_carry_flag_r});
    endproperty
    property p_raddr;
        tk |=> file_rd_addr_r == $past(instr_word[6:0]);
    endproperty
    a_skip: assert property (p_skip) else $error("skip missing");
    a_noskip: assert property (p_noskip) else $error("false skip");
    a_disc: assert property (p_disc) else $error("word not dropped");
    a_aim: assert property (p_aim) else $error("add literal wrong");
    a_nib: assert property (p_nib) else $error("nibble carry wrong");
    a_argd: assert property (p_argd) else $error("add to file wrong");
    a_bset: assert property (p_bset) else $error("bit set wrong");
    a_bflag: assert property (p_bflag) else $error("bit op moved flags");
    a_andi: assert property (p_andi) else $error("and literal wrong");
    a_andr: assert property (p_andr) else $error("and register wrong");
    a_raddr: assert property (p_raddr) else $error("read address wrong");
endmodule

bind abs_datapath abs_datapath_props u_abs_datapath_props (
    .clk, .rst_b, .instr_valid, .instr_word, .file_rd_data, .file_rd_addr_r,
    .file_wr_en_r, .file_wr_addr_r, .file_wr_data_r, .accumulator_reg_r,
    .byte_overflow_flag_r, .nibble_carry_flag_r, .result_nil_flag_r,
    .op_done_r, .nop_cycle_r, .instr_discard_r, .unsupported_r
);

//--- tb/abs_regfile_model.sv
// File register model with combinational read
`timescale 1ns/10ps
module abs_regfile_model (
    input  logic       clk,
    input  logic [6:0] rd_addr,
    output logic [7:0] rd_data,
    input  logic       wr_en,
    input  logic [6:0] wr_addr,
    input  logic [7:0] wr_data
);
    logic [7:0] mem [0:127];
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i);
    assign rd_data = mem[rd_addr];
    always @(posedge clk) if (wr_en) mem[wr_addr] <= wr_data;
endmodule

//--- tb/abs_datapath_tb.sv
// Self-checking bench of the execution datapath
`timescale 1ns/10ps
module abs_datapath_tb;
    typedef struct packed {
        logic        v;
        logic [13:0] w;
        logic [7:0]  acc;
        logic [2:0]  f;
        logic        we;
        logic [7:0]  wd;
        logic [3:0]  st;
    } abs_row_t;
    logic        clk;
    logic        rst_b;
    logic        instr_valid;
    logic [13:0] instr_word;
    wire  [7:0]  file_rd_data;
    wire  [6:0]  file_wr_addr_r;
    wire  [7:0]  file_wr_data_r;
    wire  [7:0]  accumulator_reg_r;
    wire         file_wr_en_r, byte_overflow_flag_r, nibble_carry_flag_r, result_nil_flag_r;
    wire         op_done_r, nop_cycle_r, instr_discard_r, unsupported_r;
    int          n_fail;
    int          n_checks;
    // Mem starts as mem[i] = i; status is done, nop, discard, unsupported
    abs_row_t rows [0:20] = '{
        '{1'b1, 14'h3eff, 8'hff, 3'h0, 1'b0, 8'h00, 4'h8},
        '{1'b1, 14'h3e01, 8'h00, 3'h7, 1'b0, 8'h00, 4'h8},
        '{1'b1, 14'h3e08, 8'h08, 3'h0, 1'b0, 8'h00, 4'h8},
        '{1'b1, 14'h3f08, 8'h10, 3'h2, 1'b0, 8'h00, 4'h8},
        '{1'b1, 14'h390f, 8'h00, 3'h3, 1'b0, 8'h00, 4'h8},
        '{1'b1, 14'h0705, 8'h05, 3'h0, 1'b0, 8'h00, 4'h8},
        '{1'b1, 14'h07ff, 8'h05, 3'h2, 1'b1, 8'h84, 4'h8},
        '{1'b1, 14'h077f, 8'h89, 3'h0, 1'b0, 8'h00, 4'h8},
        '{1'b1, 14'h0583, 8'h89, 3'h0, 1'b1, 8'h01, 4'h8},
        '{1'b1, 14'h0570, 8'h00, 3'h1, 1'b0, 8'h00, 4'h8},
        '{1'b1, 14'h1783, 8'h00, 3'h1, 1'b1, 8'h81, 4'h8},
        '{1'b1, 14'h1003, 8'h00, 3'h1, 1'b1, 8'h80, 4'h8},
        '{1'b1, 14'h1f83, 8'h00, 3'h1, 1'b0, 8'h00, 4'hc},
        '{1'b1, 14'h3e01, 8'h00, 3'h1, 1'b0, 8'h00, 4'h2},
        '{1'b1, 14'h1803, 8'h00, 3'h1, 1'b0, 8'h00, 4'hc},
        '{1'b0, 14'h0000, 8'h00, 3'h1, 1'b0, 8'h00, 4'h0},
        '{1'b1, 14'h1c03, 8'h00, 3'h1, 1'b0, 8'h00, 4'h8},
        '{1'b1, 14'h3e01, 8'h01, 3'h0, 1'b0, 8'h00, 4'h8},
        '{1'b1, 14'h1b83, 8'h01, 3'h0, 1'b0, 8'h00, 4'h8},
        '{1'b1, 14'h3a00, 8'h01, 3'h0, 1'b0, 8'h00, 4'h1},
        '{1'b1, 14'h3eff, 8'h00, 3'h7, 1'b0, 8'h00, 4'h8}
    };
    ////////////////////////////////////////////////////////////////////////////
    // Design and register file
    abs_datapath u_abs_datapath (
        .clk, .rst_b, .instr_valid, .instr_word, .file_rd_data, .file_rd_addr_r (),
        .file_wr_en_r, .file_wr_addr_r, .file_wr_data_r, .accumulator_reg_r,
        .byte_overflow_flag_r, .nibble_carry_flag_r, .result_nil_flag_r,
        .op_done_r, .nop_cycle_r, .instr_discard_r, .unsupported_r
    );
    abs_regfile_model u_abs_regfile_model (
        .clk     (clk),
        .rd_addr (instr_word[6:0]),
        .rd_data (file_rd_data),
        .wr_en   (file_wr_en_r),
        .wr_addr (file_wr_addr_r),
        .wr_data (file_wr_data_r)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_row(input abs_row_t r);
        chk(accumulator_reg_r, r.acc, "acc");
        chk({5'h0, byte_overflow_flag_r, nibble_carry_flag_r, result_nil_flag_r},
            {5'h0, r.f}, "flags");
        chk({7'h0, file_wr_en_r}, {7'h0, r.we}, "wr_en");
        if (r.we) chk(file_wr_data_r, r.wd, "wr_data");
        if (r.we) chk({1'b0, file_wr_addr_r}, {1'b0, r.w[6:0]}, "wr_addr");
        chk({4'h0, op_done_r, nop_cycle_r, instr_discard_r, unsupported_r},
            {4'h0, r.st}, "status");
    endtask
    task automatic finish_test;
        if (n_fail == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (500) @(posedge clk);
        n_fail++;
        finish_test;
    end
    initial begin
        n_fail = 0;
        n_checks = 0;
        rst_b = 1'b0;
        instr_valid = 1'b0;
        instr_word = 14'h0;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            @(negedge clk);
            if (i > 0) chk_row(rows[i-1]);
            instr_valid = rows[i].v;
            instr_word = rows[i].w;
        end
        @(negedge clk);
        chk_row(rows[20]);
        instr_valid = 1'b0;
        rst_b = 1'b0;
        #1;
        chk(accumulator_reg_r, 8'h00, "acc in reset");
        chk({5'h0, byte_overflow_flag_r, nibble_carry_flag_r, result_nil_flag_r},
            8'h00, "flags in reset");
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        instr_valid = 1'b1;
        instr_word = 14'h3e05;
        @(negedge clk);
        instr_valid = 1'b0;
        chk(accumulator_reg_r, 8'h05, "acc after reset");
        chk({7'h0, op_done_r}, 8'h01, "done after reset");
        finish_test;
    end
endmodule
